// [src/smc_top.v]
/*
 * Sensor master control: serial slave front end, register file and two
 * channels of protection and receive logic.
 * Assumes mclk at 20 MHz; serial pins, straps and analog flags are
 * asynchronous; framer handshakes are on mclk.
 */
// How it works
// - Supply switch off after blanking; stays off or retries after delay.
// - Dynamic blanking enabled and output below 18V shortens the blanking.
// - Doubling bit and supply above 18V allow twice the load current.
// - One shared 2-bit field selects both line driver current limits.
// - Driver off above 160C, back on only below 145C.
// - Driver fault only after overcurrent outlasts the configured blanking.
// - Short-circuit fault sets live and latched fault status bits.
// - Without autoretry keep driving; with it disable then re-enable.
// - Reverse line condition disables driver silently, no fault bit.
// - Reverse plus diode overheat without fault cuts the supply at once.
// - Pull current from 2-bit select, off while the driver drives.
// - Receive output inverted by default, true when inversion bit set.
// - Filter enable applies a 1.3us glitch filter to the receiver.
// - Aux input source and sink follow their enable bits.
// - Serial output released whenever chip select is high.
// - Mode 0 serial framing with byte and burst cycles.
// - Every cycle to the matching address returns interrupt status, and ready and error status when enabled.
// - Only the matching 2-bit strap address is answered.
// - Trigger commands act whatever address they carry.
// - Interrupt bit from the third clock, mirrors pin, unmaskable.
// - Ready enable adds ready and error bits per channel.
// - Supply lockout leaves registers unchanged; missing supply ignores interface.
// - In-band ready and error bits are inverse of their pins.
// - Ready clears once the channel message is read out.
// - Burst on a data register keeps the address fixed.
// - Burst above data registers increments the address per byte.
`timescale 1ns/1ps
`default_nettype none
`include "smc_consts.vh"

module smc_top #(
  parameter integer SUP_BLANK = (`SMC_SUP_BLANK_US * `SMC_CLK_KHZ) / 1000,
  parameter integer SUP_DYN   = (`SMC_SUP_DYN_US * `SMC_CLK_KHZ) / 1000,
  parameter integer SUP_RETRY = (`SMC_SUP_RETRY_US * `SMC_CLK_KHZ) / 1000
) (
  input  wire       mclk,
  input  wire       arst_n,
  input  wire       logic_supply_ok,
  input  wire       sclk,
  input  wire       cs_n,
  input  wire       sdi,
  output reg        sdo,
  output reg        sdo_oe,
  input  wire       chip_addr_hi,
  input  wire       chip_addr_lo,
  input  wire       irq_active,
  input  wire [1:0] msg_done,
  input  wire [1:0] msg_err,
  input  wire [7:0] rx_data_a,
  input  wire [7:0] rx_data_b,
  input  wire [1:0] rx_last,
  output reg  [1:0] rx_pop,
  output reg  [1:0] reply_ready_n,
  output reg  [1:0] reply_error_n,
  output reg  [1:0] trigger,
  input  wire [1:0] comm_line,
  input  wire [1:0] tx_active,
  input  wire [1:0] sup_limit,
  input  wire [1:0] sup_below18,
  input  wire [1:0] drv_oc,
  input  wire [1:0] temp_hi,
  input  wire [1:0] temp_cool,
  input  wire [1:0] reverse,
  input  wire [1:0] diode_hot,
  output reg  [1:0] receive_out,
  output wire [1:0] supply_gate_drive,
  output wire [1:0] supply_current_double_enable,
  output wire [1:0] driver_enable,
  output wire [3:0] pull_current_select,
  output reg  [1:0] driver_limit_select,
  output reg  [1:0] aux_source_enable,
  output reg  [1:0] aux_sink_enable
);

  reg  [21:0] sy1;
  reg  [21:0] sy2;
  reg         sclk_d;
  reg         act_d;
  reg  [2:0]  bitcnt;
  reg         first;
  reg         match;
  reg         is_rd;
  reg         is_trig;
  reg  [4:0]  reg_addr;
  reg  [6:0]  rx_sr;
  reg  [7:0]  tx_sr;
  reg  [1:0]  pend_pop;
  reg  [1:0]  pend_clr;
  reg  [1:0]  fault_clr;
  reg  [1:0]  ready;
  reg  [1:0]  err;
  reg  [15:0] msg_cfg;
  reg  [15:0] line_cfg;
  reg  [15:0] sup_cfg;
  reg  [15:0] aux_cfg;
  reg  [7:0]  drv_cfg;
  wire [1:0]  fault_live;
  wire [1:0]  fault_latched;
  wire [1:0]  filt;
  wire        s_sclk;
  wire        s_cs_n;
  wire        s_sdi;
  wire        s_vl;
  wire [1:0]  s_addr;
  wire        act;
  wire        rise;
  wire        fall;
  wire [7:0]  byte_in;
  wire [4:0]  load_addr;

  ////////////////////////////////////////////////////////////////////////////
  // Two-stage synchronisers for every asynchronous input.
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sy1 <= 22'h0;
      sy2 <= 22'h0;
    end else begin
      sy1 <= {diode_hot, reverse, temp_cool, temp_hi, drv_oc, sup_below18,
              sup_limit, comm_line, chip_addr_hi, chip_addr_lo,
              logic_supply_ok, sdi, cs_n, sclk};
      sy2 <= sy1;
    end
  end

  assign s_sclk = sy2[0];
  assign s_cs_n = sy2[1];
  assign s_sdi  = sy2[2];
  assign s_vl   = sy2[3];
  assign s_addr = {sy2[5], sy2[4]};

  // A missing logic supply makes the interface look deselected.
  assign act  = !s_cs_n && s_vl;
  assign rise = act && s_sclk && !sclk_d;
  assign fall = act && !s_sclk && sclk_d;
  assign byte_in = {rx_sr, s_sdi};

  // Address of the next byte: fixed on data registers, else incrementing.
  function [4:0] next_addr;
    input [4:0] a;
    begin
      if (a > `SMC_REG_DATA_B) begin
        next_addr = a + 5'h01;
      end else begin
        next_addr = a;
      end
    end
  endfunction

  assign load_addr = first ? byte_in[4:0] : next_addr(reg_addr);

  // Read view of the register file.
  function [7:0] rd_val;
    input [4:0] a;
    begin
      case (a)
        `SMC_REG_DATA_A:  rd_val = rx_data_a;
        `SMC_REG_DATA_B:  rd_val = rx_data_b;
        `SMC_REG_MSG_A:   rd_val = msg_cfg[7:0];
        `SMC_REG_MSG_B:   rd_val = msg_cfg[15:8];
        `SMC_REG_LINE_A:  rd_val = line_cfg[7:0];
        `SMC_REG_LINE_B:  rd_val = line_cfg[15:8];
        `SMC_REG_SUP_A:   rd_val = sup_cfg[7:0];
        `SMC_REG_SUP_B:   rd_val = sup_cfg[15:8];
        `SMC_REG_DRV_LIM: rd_val = drv_cfg;
        `SMC_REG_STAT_A:  rd_val = {6'h00, fault_latched[0], fault_live[0]};
        `SMC_REG_STAT_B:  rd_val = {6'h00, fault_latched[1], fault_live[1]};
        `SMC_REG_AUX_A:   rd_val = aux_cfg[7:0];
        `SMC_REG_AUX_B:   rd_val = aux_cfg[15:8];
        default:          rd_val = 8'h00;
      endcase
    end
  endfunction

  // Status bit shown on the serial output during the command byte.
  function status_bit;
    input [2:0] n;
    begin
      case (n)
        3'd2:    status_bit = match && irq_active;
        3'd3:    status_bit = match && msg_cfg[`SMC_MSG_RDY_EN] && ready[0];
        3'd4:    status_bit = match && msg_cfg[`SMC_MSG_RDY_EN] && err[0];
        3'd5:    status_bit = match && msg_cfg[8+`SMC_MSG_RDY_EN] && ready[1];
        3'd6:    status_bit = match && msg_cfg[8+`SMC_MSG_RDY_EN] && err[1];
        default: status_bit = 1'b0;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Serial framing, command decode and register writes.
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sclk_d    <= 1'b0;
      act_d     <= 1'b0;
      bitcnt    <= 3'h0;
      first     <= 1'b1;
      match     <= 1'b0;
      is_rd     <= 1'b0;
      is_trig   <= 1'b0;
      reg_addr  <= 5'h00;
      rx_sr     <= 7'h00;
      tx_sr     <= 8'h00;
      sdo       <= 1'b0;
      sdo_oe    <= 1'b0;
      pend_pop  <= 2'b00;
      pend_clr  <= 2'b00;
      rx_pop    <= 2'b00;
      fault_clr <= 2'b00;
      trigger   <= 2'b00;
      msg_cfg   <= {`SMC_RST_CFG, `SMC_RST_CFG};
      line_cfg  <= {`SMC_RST_CFG, `SMC_RST_CFG};
      sup_cfg   <= {`SMC_RST_CFG, `SMC_RST_CFG};
      aux_cfg   <= {`SMC_RST_CFG, `SMC_RST_CFG};
      drv_cfg   <= `SMC_RST_DRV_LIM;
    end else begin
      sclk_d    <= s_sclk;
      act_d     <= act;
      rx_pop    <= 2'b00;
      fault_clr <= 2'b00;
      trigger   <= 2'b00;
      if (!act) begin
        sdo    <= 1'b0;
        sdo_oe <= 1'b0;
        bitcnt <= 3'h0;
        first  <= 1'b1;
        match  <= 1'b0;
        {pend_pop, pend_clr} <= 4'h0; // A prefetch never clocked out must not pop later.
      end else if (!act_d) begin
        sdo    <= 1'b0;
        sdo_oe <= 1'b1;
        tx_sr  <= 8'h00;
      end else if (rise) begin
        rx_sr  <= byte_in[6:0];
        bitcnt <= bitcnt + 3'h1;
        if (first && bitcnt == 3'd1) begin
          match <= byte_in[1:0] == s_addr;
        end
        // Side effects of a read land only once the first bit of the byte is clocked out.
        if (!first && bitcnt == 3'd0) begin
          rx_pop    <= pend_pop;
          fault_clr <= pend_clr;
          pend_pop  <= 2'b00;
          pend_clr  <= 2'b00;
        end
        if (bitcnt == 3'd7) begin
          first    <= 1'b0;
          reg_addr <= load_addr;
          if (first) begin
            is_rd   <= byte_in[`SMC_CMD_RD] && match;
            is_trig <= !byte_in[`SMC_CMD_RD] && byte_in[4:0] == `SMC_REG_TRIG;
          end else if (is_trig) begin
            trigger <= byte_in[1:0];
          end else if (match && !is_rd) begin
            case (reg_addr)
              `SMC_REG_MSG_A:   msg_cfg[7:0]   <= byte_in;
              `SMC_REG_MSG_B:   msg_cfg[15:8]  <= byte_in;
              `SMC_REG_LINE_A:  line_cfg[7:0]  <= byte_in;
              `SMC_REG_LINE_B:  line_cfg[15:8] <= byte_in;
              `SMC_REG_SUP_A:   sup_cfg[7:0]   <= byte_in;
              `SMC_REG_SUP_B:   sup_cfg[15:8]  <= byte_in;
              `SMC_REG_DRV_LIM: drv_cfg        <= byte_in;
              `SMC_REG_AUX_A:   aux_cfg[7:0]   <= byte_in;
              `SMC_REG_AUX_B:   aux_cfg[15:8]  <= byte_in;
              default:          drv_cfg        <= drv_cfg;
            endcase
          end
          // Prefetch the next read byte.
          if ((first && byte_in[`SMC_CMD_RD] && match) || (!first && is_rd)) begin
            tx_sr    <= rd_val(load_addr);
            pend_pop <= {load_addr == `SMC_REG_DATA_B, load_addr == `SMC_REG_DATA_A};
            pend_clr <= {load_addr == `SMC_REG_STAT_B, load_addr == `SMC_REG_STAT_A};
          end else begin
            tx_sr <= 8'h00;
          end
        end
      end else if (fall) begin
        if (first) begin
          sdo    <= status_bit(bitcnt);
          sdo_oe <= bitcnt < 3'd2 || match;
        end else begin
          sdo   <= tx_sr[7];
          tx_sr <= {tx_sr[6:0], 1'b0};
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reply ready and error flags and their active-low pins.
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ready         <= 2'b00;
      err           <= 2'b00;
      reply_ready_n <= 2'b11;
      reply_error_n <= 2'b11;
    end else begin
      // A new message wins over the read-out clear in the same cycle.
      ready         <= msg_done | (ready & ~(rx_pop & rx_last));
      err           <= msg_err | (err & ~(rx_pop & rx_last));
      reply_ready_n <= ~(msg_done | (ready & ~(rx_pop & rx_last)));
      reply_error_n <= ~(msg_err | (err & ~(rx_pop & rx_last)));
    end
  end

  // Shared limit field and aux input current enables.
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      driver_limit_select <= 2'b00;
      aux_source_enable   <= 2'b00;
      aux_sink_enable     <= 2'b00;
      receive_out         <= 2'b11;
    end else begin
      driver_limit_select <= drv_cfg[`SMC_DRV_LIM+1:`SMC_DRV_LIM];
      aux_source_enable   <= {aux_cfg[8+`SMC_AUX_SRC], aux_cfg[`SMC_AUX_SRC]};
      aux_sink_enable     <= {aux_cfg[8+`SMC_AUX_SNK], aux_cfg[`SMC_AUX_SNK]};
      receive_out         <= filt ^ ~{msg_cfg[8+`SMC_MSG_INV], msg_cfg[`SMC_MSG_INV]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-channel protection and receive filter.
  genvar c;
  generate
    for (c = 0; c < 2; c = c + 1) begin : g_ch
      smc_chan #(
        .SUP_BLANK (SUP_BLANK),
        .SUP_DYN   (SUP_DYN),
        .SUP_RETRY (SUP_RETRY)
      ) u_chan (
        .mclk                  (mclk),
        .arst_n                (arst_n),
        .sup_cfg               (sup_cfg[8*c+7:8*c]),
        .line_cfg              (line_cfg[8*c+7:8*c]),
        .drv_cfg               (drv_cfg),
        .tx_active             (tx_active[c]),
        .sup_limit             (sy2[8+c]),
        .sup_below18           (sy2[10+c]),
        .drv_oc                (sy2[12+c]),
        .temp_hi               (sy2[14+c]),
        .temp_cool             (sy2[16+c]),
        .reverse               (sy2[18+c]),
        .diode_hot             (sy2[20+c]),
        .fault_clr             (fault_clr[c]),
        .supply_gate_drive     (supply_gate_drive[c]),
        .supply_current_double (supply_current_double_enable[c]),
        .driver_enable         (driver_enable[c]),
        .pull_current_select   (pull_current_select[2*c+1:2*c]),
        .fault_live            (fault_live[c]),
        .fault_latched         (fault_latched[c])
      );
      smc_filt u_filt (
        .mclk   (mclk),
        .arst_n (arst_n),
        .en     (line_cfg[8*c+`SMC_LINE_FILT]),
        .raw    (sy2[6+c]),
        .filt   (filt[c])
      );
    end
  endgenerate

endmodule
`default_nettype wire

// [src/smc_consts.vh]
/*
 * Shared constants of the sensor master control block: register indices,
 * field positions, reset values and timing figures.
 * Assumes it is included by its bare name from the design files.
 */
`ifndef SMC_CONSTS_VH
`define SMC_CONSTS_VH

// Register indices carried in the low five bits of the command byte.
`define SMC_REG_DATA_A   5'h00
`define SMC_REG_DATA_B   5'h01
`define SMC_REG_MSG_A    5'h02
`define SMC_REG_MSG_B    5'h03
`define SMC_REG_LINE_A   5'h04
`define SMC_REG_LINE_B   5'h05
`define SMC_REG_SUP_A    5'h06
`define SMC_REG_SUP_B    5'h07
`define SMC_REG_DRV_LIM  5'h08
`define SMC_REG_STAT_A   5'h09
`define SMC_REG_STAT_B   5'h0A
`define SMC_REG_AUX_A    5'h0B
`define SMC_REG_AUX_B    5'h0C
`define SMC_REG_TRIG     5'h1F

// Command byte layout.
`define SMC_CMD_ADDR_HI  7
`define SMC_CMD_RD       5

// message_control fields.
`define SMC_MSG_INV      0
`define SMC_MSG_RDY_EN   1
// line_config fields.
`define SMC_LINE_PULL    0
`define SMC_LINE_FILT    2
`define SMC_LINE_DRV_EN  3
// Supply configuration fields.
`define SMC_SUP_EN       0
`define SMC_SUP_RETRY    1
`define SMC_SUP_DYN      2
`define SMC_SUP_DBL      3
// driver_limit_config fields.
`define SMC_DRV_LIM      0
`define SMC_DRV_BLANK    2
`define SMC_DRV_RETRY    4
// channel_status fields.
`define SMC_STAT_LIVE    0
`define SMC_STAT_LATCH   1
// aux_input_config fields.
`define SMC_AUX_SRC      0
`define SMC_AUX_SNK      1

// Reset values.
`define SMC_RST_CFG      8'h00
`define SMC_RST_DRV_LIM  8'h00

// Timing figures in their own units and the clock rate.
`define SMC_CLK_KHZ      20000
`define SMC_FILT_NS      1300
`define SMC_SUP_BLANK_US 5000
`define SMC_SUP_DYN_US   500
`define SMC_SUP_RETRY_US 100000
`define SMC_DRV_STEP_NS  10000
`define SMC_DRV_RETRY_US 100

`endif

// [src/smc_filt.v]
/*
 * Glitch filter for one line receiver: the output follows the input only
 * after the input has held a new level for CYC clocks.
 * Assumes its input is already synchronised to mclk.
 */
`timescale 1ns/1ps
`default_nettype none
`include "smc_consts.vh"

module smc_filt #(
  parameter integer CYC = (`SMC_FILT_NS * `SMC_CLK_KHZ) / 1000000
) (
  input  wire       mclk,
  input  wire       arst_n,
  input  wire       en,
  input  wire       raw,
  output reg        filt
);

  reg [7:0] cnt;

  // Count how long the input differs; bypass when the filter is off.
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cnt  <= 8'h00;
      filt <= 1'b0;
    end else if (!en || raw == filt) begin
      cnt  <= 8'h00;
      filt <= raw;
    end else if (cnt >= CYC[7:0] - 8'h01) begin
      cnt  <= 8'h00;
      filt <= raw;
    end else begin
      cnt  <= cnt + 8'h01;
    end
  end

endmodule
`default_nettype wire

// [src/smc_chan.v]
/*
 * Protection state of one channel: supply switch blanking and autoretry,
 * line driver fault, thermal and reverse shutdown, pull current gating.
 * Assumes all status inputs are synchronised to mclk.
 */
`timescale 1ns/1ps
`default_nettype none
`include "smc_consts.vh"

module smc_chan #(
  parameter integer SUP_BLANK = (`SMC_SUP_BLANK_US * `SMC_CLK_KHZ) / 1000,
  parameter integer SUP_DYN   = (`SMC_SUP_DYN_US * `SMC_CLK_KHZ) / 1000,
  parameter integer SUP_RETRY = (`SMC_SUP_RETRY_US * `SMC_CLK_KHZ) / 1000
) (
  input  wire       mclk,
  input  wire       arst_n,
  input  wire [7:0] sup_cfg,
  input  wire [7:0] line_cfg,
  input  wire [7:0] drv_cfg,
  input  wire       tx_active,
  input  wire       sup_limit,
  input  wire       sup_below18,
  input  wire       drv_oc,
  input  wire       temp_hi,
  input  wire       temp_cool,
  input  wire       reverse,
  input  wire       diode_hot,
  input  wire       fault_clr,
  output reg        supply_gate_drive,
  output reg        supply_current_double,
  output reg        driver_enable,
  output reg  [1:0] pull_current_select,
  output reg        fault_live,
  output reg        fault_latched
);

  localparam [1:0] S_ON    = 2'b00;
  localparam [1:0] S_HOLD  = 2'b01;
  localparam [1:0] S_RETRY = 2'b10;
  localparam integer DRV_STEP  = (`SMC_DRV_STEP_NS * `SMC_CLK_KHZ) / 1000000;
  localparam integer DRV_RETRY = (`SMC_DRV_RETRY_US * `SMC_CLK_KHZ) / 1000;

  reg  [1:0]  state;
  reg  [23:0] scnt;
  reg  [15:0] dcnt;
  reg  [15:0] rcnt;
  reg         therm;
  reg         retry_off;
  wire [23:0] sup_lim;
  wire [15:0] drv_lim;
  wire        sup_en;
  wire        driving;

  assign sup_en  = sup_cfg[`SMC_SUP_EN];
  // Short blanking only when enabled and the output is still low.
  assign sup_lim = (sup_cfg[`SMC_SUP_DYN] && sup_below18) ? SUP_DYN[23:0]
                                                          : SUP_BLANK[23:0];
  assign drv_lim = DRV_STEP[15:0] * ({14'h0, drv_cfg[`SMC_DRV_BLANK+1:`SMC_DRV_BLANK]} + 16'h1);
  assign driving = driver_enable && tx_active;

  ////////////////////////////////////////////////////////////////////////////
  // Supply switch: blanking, autoretry, overheat cut-off.
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state <= S_ON;
      scnt  <= 24'h0;
    end else begin
      case (state)
        S_ON: begin
          if (sup_en && reverse && diode_hot && !fault_live) begin
            state <= S_HOLD;
            scnt  <= 24'h0;
          end else if (!sup_en || !sup_limit) begin
            scnt <= 24'h0;
          end else if (scnt >= sup_lim - 24'h1) begin
            state <= sup_cfg[`SMC_SUP_RETRY] ? S_RETRY : S_HOLD;
            scnt  <= 24'h0;
          end else begin
            scnt <= scnt + 24'h1;
          end
        end
        S_HOLD: begin
          if (!sup_en) begin
            state <= S_ON;
          end
        end
        S_RETRY: begin
          if (!sup_en || scnt >= SUP_RETRY[23:0] - 24'h1) begin
            state <= S_ON;
            scnt  <= 24'h0;
          end else begin
            scnt <= scnt + 24'h1;
          end
        end
        default: begin
          state <= S_ON;
          scnt  <= 24'h0;
        end
      endcase
    end
  end

  // Line driver: thermal hysteresis, overcurrent blanking, retry gap.
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      therm         <= 1'b0;
      dcnt          <= 16'h0;
      rcnt          <= 16'h0;
      retry_off     <= 1'b0;
      fault_live    <= 1'b0;
      fault_latched <= 1'b0;
    end else begin
      if (temp_hi) begin
        therm <= 1'b1;
      end else if (temp_cool) begin
        therm <= 1'b0;
      end
      if (!drv_oc || !driver_enable) begin
        dcnt       <= 16'h0;
        fault_live <= 1'b0;
      end else if (dcnt >= drv_lim - 16'h1) begin
        fault_live <= 1'b1;
      end else begin
        dcnt <= dcnt + 16'h1;
      end
      if (retry_off) begin
        rcnt      <= rcnt + 16'h1;
        retry_off <= (rcnt < DRV_RETRY[15:0] - 16'h1);
      end else if (fault_live && drv_cfg[`SMC_DRV_RETRY]) begin
        rcnt      <= 16'h0;
        retry_off <= 1'b1;
      end
      // A new fault wins over a software clear in the same cycle.
      if (fault_live) begin
        fault_latched <= 1'b1;
      end else if (fault_clr) begin
        fault_latched <= 1'b0;
      end
    end
  end

  // Registered drive outputs.
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      supply_gate_drive     <= 1'b0;
      supply_current_double <= 1'b0;
      driver_enable         <= 1'b0;
      pull_current_select   <= 2'b00;
    end else begin
      supply_gate_drive     <= sup_en && state == S_ON;
      supply_current_double <= sup_cfg[`SMC_SUP_DBL] && !sup_below18;
      driver_enable         <= line_cfg[`SMC_LINE_DRV_EN] && !therm && !reverse
                               && !retry_off;
      pull_current_select   <= driving ? 2'b00
                               : line_cfg[`SMC_LINE_PULL+1:`SMC_LINE_PULL];
    end
  end

endmodule
`default_nettype wire

// [test/smc_top_sva.sv]
/* Port checker of the sensor master control block.
   Assumes a bind from the bench top file. */
`timescale 1ns/1ps
`default_nettype none
module smc_top_sva (
  input wire logic       mclk,
  input wire logic       arst_n,
  input wire logic       cs_n,
  input wire logic       sdo_oe,
  input wire logic [1:0] msg_done,
  input wire logic [1:0] rx_pop,
  input wire logic [1:0] reply_ready_n,
  input wire logic [1:0] trigger,
  input wire logic [1:0] tx_active,
  input wire logic [1:0] drv_oc,
  input wire logic [1:0] temp_hi,
  input wire logic [1:0] reverse,
  input wire logic [1:0] diode_hot,
  input wire logic [1:0] supply_gate_drive,
  input wire logic [1:0] driver_enable,
  input wire logic [3:0] pull_current_select
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  // Bounds allow for the two-stage input synchronisers.
  AST_SDO_OFF: assert property (cs_n [*6] |-> !sdo_oe)
    else $error("sdo driven while deselected");
  AST_PULL_A: assert property ((tx_active[0] && driver_enable[0]) [*3]
    |-> pull_current_select[1:0] == 2'h0)
    else $error("pull on while A drives");
  AST_PULL_B: assert property ((tx_active[1] && driver_enable[1]) [*3]
    |-> pull_current_select[3:2] == 2'h0)
    else $error("pull on while B drives");
  AST_HOT_OFF: assert property (temp_hi[0] [*5] |-> !driver_enable[0])
    else $error("driver on while hot");
  AST_REV_OFF: assert property (reverse[0] [*5] |-> !driver_enable[0])
    else $error("driver on during reverse");
  AST_DIODE: assert property ((reverse[0] && diode_hot[0] && !drv_oc[0]) [*5]
    |-> !supply_gate_drive[0])
    else $error("supply on with hot diode");
  AST_RDY_SET: assert property (msg_done[0] |-> ##[1:3] !reply_ready_n[0])
    else $error("ready pin not asserted");
  AST_TRIG: assert property (trigger[0] |-> !cs_n ##1 !trigger[0])
    else $error("trigger outside a cycle");
  // Main scenarios seen.
  cover property (trigger[0]);
  cover property (rx_pop[0]);
  cover property (msg_done[0]);
endmodule
`default_nettype wire

// [test/smc_host.sv]
/* Serial host model, mode 0, 400 ns clock.
   Assumes the bench calls its tasks one at a time. */
`timescale 1ns/1ps
`default_nettype none
module smc_host (
  output logic     sclk,
  output logic     cs_n,
  output logic     sdi,
  input wire logic sdo,
  input wire logic sdo_oe
);
  // A released output reads back inverted, never as a held value.
  wire miso = sdo_oe ? sdo : ~sdo;
  initial {sclk, cs_n, sdi} = 3'h2;
  // Shifts a byte MSB first: data set while low, taken on the rise.
  task automatic xb(input logic [7:0] o, output logic [7:0] i);
    for (int k = 7; k >= 0; k--) begin
      sdi = o[k];
      #250 sclk = 1;
      i[k] = miso;
      #150 sclk = 0;
    end
  endtask
  // Opens and closes a cycle with settling gaps.
  task go();
    cs_n = 0;
    #250;
  endtask
  task stop();
    #250 cs_n = 1;
    #400;
  endtask
endmodule
`default_nettype wire

// [test/sensor_master_ctrl_spi_tb.sv]
/* Bench of the sensor master control block.
   Assumes the host model and checker are compiled first. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin error_cnt++; \
  $display("[FAIL] %0t %h %h", $time, (a), (e)); end end
module sensor_master_ctrl_spi_tb;
  logic       mclk = 0, arst_n = 0, irq_active = 0, logic_supply_ok = 1;
  logic       chip_addr_hi = 1, chip_addr_lo = 0;
  logic [1:0] msg_done = 0, msg_err = 0, rx_last = 0, comm_line = 0, tx_active = 0;
  logic [1:0] sup_limit = 0, sup_below18 = 0, drv_oc = 0, temp_hi = 0, temp_cool = 3;
  logic [1:0] reverse = 0, diode_hot = 0, trig_seen = 0;
  logic [7:0] rx_data_a = 0, rx_data_b = 0, st, d;
  int         error_cnt = 0, num_checks = 0;
  wire        sclk, cs_n, sdi, sdo, sdo_oe;
  wire  [1:0] rx_pop, reply_ready_n, reply_error_n, trigger, receive_out, supply_gate_drive;
  wire  [1:0] supply_current_double_enable, driver_enable, driver_limit_select;
  wire  [1:0] aux_source_enable, aux_sink_enable;
  wire  [3:0] pull_current_select;
  smc_top #(.SUP_BLANK(20), .SUP_DYN(5), .SUP_RETRY(30)) u_dut (.*);
  smc_host u_host (.*);
  // Clock and a sticky record of trigger pulses.
  initial forever #25 mclk = ~mclk;
  always @(posedge mclk) trig_seen <= trig_seen | trigger;
  // One write cycle to chip ca.
  task automatic wr(input logic [1:0] ca, input logic [4:0] r, input logic [7:0] v);
    u_host.go();
    u_host.xb({ca, 1'b0, r}, st);
    u_host.xb(v, d);
    u_host.stop();
  endtask
  // One two-byte read cycle to this chip: status in st, data in d.
  task automatic rd(input logic [4:0] r);
    u_host.go();
    u_host.xb({2'h2, 1'b1, r}, st);
    u_host.xb(8'h00, d);
    u_host.stop();
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task finish_test();
    if (error_cnt == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Main sequence.
  initial begin
    tick(5);
    arst_n = 1;
    tick(4);
    wr(2'h2, 5'h04, 8'h0A);
    `CHK(pull_current_select, 4'h2)
    tx_active = 2'h3;
    tick(4);
    `CHK(pull_current_select, 4'h0)
    tx_active = 0;
    temp_hi = 1;
    temp_cool = 2;
    tick(8);
    `CHK(driver_enable, 2'h0)
    temp_hi = 0;
    tick(8);
    `CHK(driver_enable, 2'h0)
    temp_cool = 3;
    tick(8);
    `CHK(driver_enable, 2'h1)
    sup_below18 = 1;
    wr(2'h2, 5'h06, 8'h0F);
    `CHK({supply_gate_drive, supply_current_double_enable}, 4'h4)
    sup_limit = 1;
    tick(10);
    `CHK(supply_gate_drive, 2'h0)
    sup_limit = 0;
    sup_below18 = 0;
    tick(40);
    `CHK({supply_gate_drive, supply_current_double_enable}, 4'h5)
    reverse = 1;
    diode_hot = 1;
    tick(8);
    `CHK(driver_enable, 2'h0)
    `CHK(supply_gate_drive, 2'h0)
    reverse = 0;
    diode_hot = 0;
    wr(2'h1, 5'h08, 8'h03);
    `CHK(driver_limit_select, 2'h0)
    wr(2'h2, 5'h08, 8'h03);
    `CHK(driver_limit_select, 2'h3)
    drv_oc = 1;
    rd(5'h09);
    `CHK(d, 8'h00)
    tick(100);
    rd(5'h09);
    `CHK(d, 8'h03)
    drv_oc = 0;
    rd(5'h09);
    `CHK(d, 8'h02)
    rd(5'h09);
    `CHK(d, 8'h00)
    u_host.go();
    u_host.xb(8'h8B, st);
    u_host.xb(8'h03, d);
    u_host.xb(8'h02, d);
    u_host.stop();
    `CHK({aux_source_enable, aux_sink_enable}, 4'h7)
    wr(2'h0, 5'h1F, 8'h03);
    `CHK(trig_seen, 2'h3)
    wr(2'h2, 5'h02, 8'h03);
    `CHK(receive_out, 2'h2)
    irq_active = 1;
    rx_last = 1;
    rx_data_a = 8'h5A;
    msg_done = 1;
    msg_err = 2;
    tick(1);
    msg_done = 0;
    msg_err = 0;
    tick(3);
    `CHK(reply_ready_n, 2'h2)
    `CHK(reply_error_n, 2'h1)
    rd(5'h00);
    `CHK(st, 8'h30)
    `CHK(d, 8'h5A)
    `CHK(reply_ready_n, 2'h3)
    finish_test();
  end
endmodule
bind smc_top smc_top_sva u_sva (.*);
`default_nettype wire
